// File: include/frt_pkg.sv
// Constants, types and timing for the flow rate totalizer control block
// Notes on behaviour
// - Auto follows setpoint, open forces fully open, closed fully shut.
// - Editing flashes; increment steps; second override press applies it.
// - Indicator blinks when forced open, steady when forced closed.
// - Remote mode: override key shows condition three seconds, no change.
// - Remote, no input active: keep last front panel condition.
// - Rate is span times normalized input, 0 at minimum, 1 at maximum.
// - Span accepted only between 0.1000 and 50000.0.
// - Rates below cutoff percent of span show zero, are not totalized.
// - No integration while the normalized input is exactly zero.
// - Averaging filter set by a constant; one passes input unfiltered.
// - Filter slows with larger constant; 99 gives 90% in 57 s.
// - Analog retransmit output is driven from the filtered normalized input.
// - Alarm alternates function and fault; beep while fault is shown.
// - High or low relay can be set to follow the alarm condition.
// - Totals divided by conversion factor, accepted from 0.01 to 2000.
// - Span is in rate units; conversion factor touches totals only.
// - Printer clear-to-send throttles output to avoid buffer overrun.
`default_nettype none
package frt_pkg;
  localparam int CLK_HZ = 200_000_000;
  // Filter step period; 227 steps at constant 99 give 90% in about 57 s
  localparam int SAMPLE_MS = 250;
  localparam int SAMPLE_CYC = (CLK_HZ / 1000) * SAMPLE_MS;
  localparam int VIEW_S = 3;
  localparam int VIEW_CYC = CLK_HZ * VIEW_S;
  localparam int ALT_MS = 1000;
  localparam int ALT_CYC = (CLK_HZ / 1000) * ALT_MS;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
  // Span in units of 0.0001, factor in units of 0.01, cutoff in 0.1 %
  localparam logic [31:0] SPAN_MIN = 32'h0000_03e8;
  localparam logic [31:0] SPAN_MAX = 32'h1dcd_6500;
  localparam logic [31:0] SPAN_RST = 32'h0000_2710;
  localparam logic [31:0] FACT_MIN = 32'h0000_0001;
  localparam logic [31:0] FACT_MAX = 32'h0003_0d40;
  localparam logic [31:0] FACT_RST = 32'h0000_0064;
  localparam logic [15:0] CUT_MAX = 16'h03e8;
  localparam logic [15:0] CUT_RST = 16'h0000;
  localparam logic [31:0] CUT_SCALE = 32'h0000_03e8;
  localparam logic [6:0] FILT_MIN = 7'h01;
  localparam logic [6:0] FILT_MAX = 7'h63;
  localparam logic [6:0] FILT_RST = 7'h01;
  localparam logic [1:0] TB_RST = 2'h0;
  // Total increment scale: sample ms times factor units per unit
  localparam logic [63:0] TOT_MUL = 64'h0000_0000_0000_61a8;
  localparam logic [63:0] TB_MS_DIV = 64'h0000_0000_0000_03e8;
  localparam logic [1:0] RELAY_HI = 2'h1;
  localparam logic [1:0] RELAY_LO = 2'h2;
  // Pin indices of the synchronised inputs
  localparam int NPIN = 8;
  localparam int PIN_OVR = 0;
  localparam int PIN_INC = 1;
  localparam int PIN_RATE = 2;
  localparam int PIN_TOTAL = 3;
  localparam int PIN_ROPEN = 4;
  localparam int PIN_RCLOSE = 5;
  localparam int PIN_ALARM = 6;
  localparam int PIN_CTS = 7;
  typedef enum logic [1:0] {COND_AUTO, COND_OPEN, COND_CLOSED} frt_cond_e;
  typedef enum logic [1:0] {UI_IDLE, UI_EDIT, UI_VIEW} frt_ui_e;
  typedef enum logic [1:0] {DISP_RATE, DISP_TOTAL, DISP_OVERRIDE, DISP_FAULT}
    frt_disp_e;
  function automatic logic [63:0] frt_tb_seconds(input logic [1:0] tb);
    case (tb)
      2'h0: return 64'h0000_0000_0000_0001;
      2'h1: return 64'h0000_0000_0000_003c;
      2'h2: return 64'h0000_0000_0000_0e10;
      default: return 64'h0000_0000_0001_5180;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: hdl/frt_flow_totalizer.sv
// Flow rate, filter, totalizer and valve override control
`timescale 1ns/100ps
`default_nettype none
module frt_flow_totalizer
  import frt_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int VIEW_CYCLES = VIEW_CYC,
  parameter int ALT_CYCLES = ALT_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC
) (
  input wire logic clk, // 200 MHz clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic ovr_key, // Valve override key pin
  input wire logic inc_key, // Increment key pin
  input wire logic rate_key, // Rate key pin
  input wire logic total_key, // Total key pin
  input wire logic remote_open, // Remote force-open pin
  input wire logic remote_close, // Remote force-closed pin
  input wire logic flow_controller_alarm_input, // Alarm pin
  input wire logic cts_in, // Printer clear-to-send pin
  input wire logic remote_sel, // Override assigned to remote inputs
  input wire logic [15:0] norm_in, // Normalized input, ffff is full
  input wire logic cal_load, // Load calibration values
  input wire logic [31:0] span_in, // Span, 0.0001 units
  input wire logic [15:0] cutoff_in, // Cutoff, 0.1 % of span
  input wire logic [6:0] filt_in, // Filter constant
  input wire logic [31:0] total_division_factor, // 0.01 units
  input wire logic [1:0] timebase_in, // s, min, h, day
  input wire logic [1:0] alarm_relay_sel, // 1 high, 2 low relay
  input wire logic total_clear, // Clear total
  output logic [31:0] rate_out, // Displayed rate, 0.0001 units
  output logic [15:0] ao_code, // Analog retransmit code
  output logic [47:0] total_out, // Total in converted units
  output logic valve_auto, // Valve regulates to setpoint
  output logic valve_open, // Valve forced open
  output logic valve_closed, // Valve forced closed
  output logic ovr_led, // Override key indicator
  output frt_disp_e disp_sel, // What the display shows
  output frt_cond_e disp_cond, // Override condition shown
  output logic disp_flash, // Display flashing
  output logic beep, // Audible beep
  output logic relay_hi_alarm, // High relay alarm drive
  output logic relay_lo_alarm, // Low relay alarm drive
  output logic print_enable // Printer may accept data
);

  if (SAMPLE_CYCLES < 2 || VIEW_CYCLES < 2 || ALT_CYCLES < 2 ||
      BLINK_CYCLES < 2) begin : g_bad_par
    $error("frt_flow_totalizer: counts must be at least 2");
  end

  // Pin synchronisers; level moves once stages two and three agree
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] pin_lvl;
  logic [NPIN-1:0] pin_prev;
  assign pin_raw = {cts_in, flow_controller_alarm_input, remote_close,
                    remote_open, total_key, rate_key, inc_key, ovr_key};
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!nrst) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
        sync3[i] <= 1'b0;
        pin_lvl[i] <= 1'b0;
        pin_prev[i] <= 1'b0;
      end else begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) begin
          pin_lvl[i] <= sync3[i];
        end
        pin_prev[i] <= pin_lvl[i];
      end
    end
  end
  wire [NPIN-1:0] press = pin_lvl & ~pin_prev;
  wire alarm = pin_lvl[PIN_ALARM];

  // Calibration values, out-of-range loads are ignored
  logic [31:0] span;
  logic [15:0] cutoff;
  logic [6:0] filt_k;
  logic [31:0] factor;
  logic [1:0] timebase;
  wire span_ok = span_in >= SPAN_MIN && span_in <= SPAN_MAX;
  wire fact_ok = total_division_factor >= FACT_MIN &&
                 total_division_factor <= FACT_MAX;
  wire cut_ok = cutoff_in <= CUT_MAX;
  wire filt_ok = filt_in >= FILT_MIN && filt_in <= FILT_MAX;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      span <= SPAN_RST;
      cutoff <= CUT_RST;
      filt_k <= FILT_RST;
      factor <= FACT_RST;
      timebase <= TB_RST;
    end else if (cal_load) begin
      if (span_ok) span <= span_in;
      if (cut_ok) cutoff <= cutoff_in;
      if (filt_ok) filt_k <= filt_in;
      if (fact_ok) factor <= total_division_factor;
      timebase <= timebase_in;
    end
  end

  // Sample tick for filter and integration steps
  logic [31:0] sample_cnt;
  wire tick = sample_cnt == 32'h0;
  always_ff @(posedge clk) begin
    if (!nrst) sample_cnt <= 32'(SAMPLE_CYCLES - 1);
    else if (tick) sample_cnt <= 32'(SAMPLE_CYCLES - 1);
    else sample_cnt <= sample_cnt - 32'h1;
  end

  // Filter state on the normalized value, Q16.16
  logic [31:0] filt;
  // exponential averaging weight one over constant
  wire signed [32:0] filt_diff = $signed({1'b0, norm_in, 16'h0}) -
                                 $signed({1'b0, filt});
  // constant one gives the full step
  wire signed [32:0] filt_step = filt_diff / $signed({26'h0, filt_k});
  wire signed [32:0] filt_sum = $signed({1'b0, filt}) + filt_step;
  // larger constant gives smaller steps per tick
  wire [31:0] next_filt = filt_sum[31:0];
  wire [15:0] filt_norm = filt[31:16];

  // rate is span times normalized input
  wire [47:0] rate_f_prod = {16'h0, span} * {32'h0, filt_norm};
  wire [47:0] rate_r_prod = {16'h0, span} * {32'h0, norm_in};
  wire [31:0] rate_filt = rate_f_prod[47:16];
  wire [31:0] rate_raw = rate_r_prod[47:16];
  // cutoff compared on the normalized scale
  wire [31:0] cut_lim = {cutoff, 16'h0};
  wire filt_below = ({16'h0, filt_norm} * CUT_SCALE) < cut_lim;
  wire raw_below = ({16'h0, norm_in} * CUT_SCALE) < cut_lim;
  wire integrate = tick && norm_in != 16'h0 && !raw_below;

  // rate times step time over timebase, over factor
  // factor only enters the total path
  wire [63:0] tot_num = ({32'h0, rate_raw} * TOT_MUL) << 16;
  wire [63:0] tot_den = frt_tb_seconds(timebase) * TB_MS_DIV *
                        {32'h0, factor};
  wire [63:0] tot_inc = tot_num / tot_den;
  logic [63:0] total_acc;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      filt <= 32'h0;
      rate_out <= 32'h0;
      ao_code <= 16'h0;
    end else if (tick) begin
      filt <= next_filt;
      rate_out <= filt_below ? 32'h0 : rate_filt;
      ao_code <= filt_norm;
    end
  end

  // Fractional bits kept so small rates still accumulate
  always_ff @(posedge clk) begin
    if (!nrst) total_acc <= 64'h0;
    else if (total_clear) total_acc <= 64'h0;
    else if (integrate) total_acc <= total_acc + tot_inc;
  end
  assign total_out = total_acc[63:16];

  // Override user interface
  frt_ui_e ui;
  frt_ui_e next_ui;
  frt_cond_e panel_cond;
  frt_cond_e next_panel;
  frt_cond_e edit_cond;
  frt_cond_e next_edit;
  frt_cond_e valve_cond;
  logic [31:0] view_cnt;
  logic [31:0] next_view;
  frt_cond_e edit_step;
  always_comb begin
    case (edit_cond)
      COND_AUTO: edit_step = COND_OPEN;
      COND_OPEN: edit_step = COND_CLOSED;
      default: edit_step = COND_AUTO;
    endcase
  end
  always_comb begin
    next_ui = ui;
    next_panel = panel_cond;
    next_edit = edit_cond;
    next_view = view_cnt;
    case (ui)
      UI_IDLE: begin
        if (press[PIN_OVR]) begin
          if (remote_sel) begin
            next_ui = UI_VIEW;
            next_view = 32'(VIEW_CYCLES - 1);
          end else begin
            next_ui = UI_EDIT;
            next_edit = panel_cond;
          end
        end
      end
      UI_EDIT: begin
        // Switching to remote abandons the edit
        if (remote_sel) begin
          next_ui = UI_IDLE;
        end else if (press[PIN_OVR]) begin
          next_panel = edit_cond;
          next_ui = UI_IDLE;
        end else if (press[PIN_INC]) begin
          next_edit = edit_step;
        end
      end
      UI_VIEW: begin
        if (view_cnt == 32'h0) next_ui = UI_IDLE;
        else next_view = view_cnt - 32'h1;
      end
      default: next_ui = UI_IDLE;
    endcase
  end

  // remote idle keeps last panel condition
  wire frt_cond_e next_valve = !remote_sel ? panel_cond :
                               pin_lvl[PIN_ROPEN] ? COND_OPEN :
                               pin_lvl[PIN_RCLOSE] ? COND_CLOSED :
                               panel_cond;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ui <= UI_IDLE;
      panel_cond <= COND_AUTO;
      edit_cond <= COND_AUTO;
      view_cnt <= 32'h0;
      valve_cond <= COND_AUTO;
    end else begin
      ui <= next_ui;
      panel_cond <= next_panel;
      edit_cond <= next_edit;
      view_cnt <= next_view;
      valve_cond <= next_valve;
    end
  end
  assign valve_auto = valve_cond == COND_AUTO;
  assign valve_open = valve_cond == COND_OPEN;
  assign valve_closed = valve_cond == COND_CLOSED;

  // Blink and alarm alternation timers
  logic [31:0] blink_cnt;
  logic blink_ph;
  logic [31:0] alt_cnt;
  logic alt_ph;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      blink_cnt <= 32'h0;
      blink_ph <= 1'b0;
    end else if (blink_cnt == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt <= 32'h0;
      blink_ph <= ~blink_ph;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end
  // Alternation restarts on the function each time the alarm rises
  always_ff @(posedge clk) begin
    if (!nrst || !alarm) begin
      alt_cnt <= 32'h0;
      alt_ph <= 1'b0;
    end else if (alt_cnt == 32'(ALT_CYCLES - 1)) begin
      alt_cnt <= 32'h0;
      alt_ph <= ~alt_ph;
    end else begin
      alt_cnt <= alt_cnt + 32'h1;
    end
  end

  // Display selection; rate and total keys ignored while editing
  logic show_total;
  always_ff @(posedge clk) begin
    if (!nrst) show_total <= 1'b0;
    else if (ui == UI_IDLE && press[PIN_TOTAL]) show_total <= 1'b1;
    else if (ui == UI_IDLE && press[PIN_RATE]) show_total <= 1'b0;
  end
  wire frt_disp_e fn_disp = show_total ? DISP_TOTAL : DISP_RATE;
  // alternate function and fault while alarm active
  wire frt_disp_e next_disp = ui != UI_IDLE ? DISP_OVERRIDE :
                              (alarm && alt_ph) ? DISP_FAULT : fn_disp;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      disp_sel <= DISP_RATE;
      disp_cond <= COND_AUTO;
      disp_flash <= 1'b0;
      beep <= 1'b0;
      ovr_led <= 1'b0;
      relay_hi_alarm <= 1'b0;
      relay_lo_alarm <= 1'b0;
      print_enable <= 1'b0;
    end else begin
      disp_sel <= next_disp;
      disp_cond <= ui == UI_EDIT ? edit_cond : valve_cond;
      disp_flash <= ui == UI_EDIT;
      beep <= next_disp == DISP_FAULT;
      ovr_led <= valve_open ? blink_ph : valve_closed;
      relay_hi_alarm <= alarm && alarm_relay_sel == RELAY_HI;
      relay_lo_alarm <= alarm && alarm_relay_sel == RELAY_LO;
      print_enable <= pin_lvl[PIN_CTS];
    end
  end

endmodule // frt_flow_totalizer
`default_nettype wire

// File: verif/frt_keypad_model.sv
// Operator keypad model driving the front panel key pins
`timescale 1ns/100ps
`default_nettype none
module frt_keypad_model (
  input wire logic clk, // Bench clock
  output logic [3:0] keys // Override, increment, rate, total
);
  initial keys = 4'h0;
  // Held well past the input synchroniser, like a human press
  task automatic press(input int k);
    @(posedge clk);
    keys[k] <= 1'b1;
    repeat (8) @(posedge clk);
    keys[k] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule // frt_keypad_model
`default_nettype wire

// File: verif/frt_flow_totalizer_asserts.sv
// Port checks for the flow rate totalizer control block
`timescale 1ns/100ps
`default_nettype none
module frt_flow_totalizer_checker
  import frt_pkg::*;
#(
  parameter int BLINK_CYCLES = 8
) (
  input wire logic clk, // Clock
  input wire logic nrst, // Reset
  input wire logic [15:0] norm_in, // Input
  input wire logic total_clear, // Clear
  input wire logic cts_in, // Printer ready
  input wire logic flow_controller_alarm_input, // Alarm
  input wire logic [1:0] alarm_relay_sel, // Relay choice
  input wire logic [47:0] total_out, // Total
  input wire logic valve_auto, // Auto
  input wire logic valve_open, // Open
  input wire logic valve_closed, // Closed
  input wire logic ovr_led, // Indicator
  input wire frt_disp_e disp_sel, // Display
  input wire logic disp_flash, // Flash
  input wire logic beep, // Beep
  input wire logic relay_hi_alarm, // High relay
  input wire logic relay_lo_alarm, // Low relay
  input wire logic print_enable // Printer enable
);
  // Half period plus slack for the register stage
  localparam int BL_MAX = BLINK_CYCLES + 4;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_beep_fault: assert property (beep == (disp_sel == DISP_FAULT))
    else $error("beep not tied to fault display");
  a_valve_one: assert property (
    $onehot({valve_auto, valve_open, valve_closed}))
    else $error("valve condition not one-hot");
  a_led_closed: assert property (valve_closed[*3] |-> ovr_led)
    else $error("indicator not lit while closed");
  a_led_blink: assert property ((valve_open && ovr_led)
    |-> ##[1:BL_MAX] (!ovr_led || !valve_open))
    else $error("indicator not blinking while open");
  a_relay_hi: assert property ((flow_controller_alarm_input
    && alarm_relay_sel == RELAY_HI)[*8] |-> relay_hi_alarm && !relay_lo_alarm)
    else $error("high relay not following alarm");
  a_relay_lo: assert property ((flow_controller_alarm_input
    && alarm_relay_sel == RELAY_LO)[*8] |-> relay_lo_alarm && !relay_hi_alarm)
    else $error("low relay not following alarm");
  a_relay_idle: assert property ((!flow_controller_alarm_input)[*8]
    |-> !relay_hi_alarm && !relay_lo_alarm && disp_sel != DISP_FAULT)
    else $error("alarm outputs active without alarm");
  a_print_cts: assert property (
    $stable(cts_in)[*8] |-> print_enable == cts_in)
    else $error("printer enable not following ready");
  a_flash_edit: assert property (
    disp_flash |-> disp_sel == DISP_OVERRIDE)
    else $error("flashing outside override display");
  a_total_hold: assert property (
    (norm_in == 16'h0000 && !total_clear)[*3] |=> $stable(total_out))
    else $error("total moved at zero input");
endmodule // frt_flow_totalizer_checker
bind frt_flow_totalizer frt_flow_totalizer_checker #(
  .BLINK_CYCLES(BLINK_CYCLES)) i_frt_flow_totalizer_checker (
  .clk(clk), .nrst(nrst), .norm_in(norm_in), .total_clear(total_clear),
  .cts_in(cts_in), .flow_controller_alarm_input(flow_controller_alarm_input),
  .alarm_relay_sel(alarm_relay_sel), .total_out(total_out),
  .valve_auto(valve_auto), .valve_open(valve_open),
  .valve_closed(valve_closed), .ovr_led(ovr_led), .disp_sel(disp_sel),
  .disp_flash(disp_flash), .beep(beep), .relay_hi_alarm(relay_hi_alarm),
  .relay_lo_alarm(relay_lo_alarm), .print_enable(print_enable));
`default_nettype wire

// File: verif/tb_frt_flow_totalizer.sv
// Self-checking bench for the flow rate totalizer control block
`timescale 1ns/100ps
`default_nettype none
module tb_frt_flow_totalizer;
  import frt_pkg::*;
  localparam int S = 16;
  localparam int V = 64;
  logic clk = 1'b0, nrst = 1'b0, cal_load = 1'b0, total_clear = 1'b0;
  logic remote_sel = 1'b0, remote_open = 1'b0, remote_close = 1'b0;
  logic alarm = 1'b0, cts_in = 1'b0;
  logic [15:0] norm_in = 16'h0000, cutoff_in = 16'h0000, ao_code, old;
  logic [31:0] span_in = 32'h2710, fact = 32'h64, rate_out, rs = 32'h42;
  logic [6:0] filt_in = 7'h01;
  logic [1:0] tb_in = 2'h0, rly = 2'h0;
  logic [3:0] keys;
  logic [47:0] total_out, e;
  logic valve_auto, valve_open, valve_closed, ovr_led, disp_flash, beep;
  logic relay_hi_alarm, relay_lo_alarm, print_enable;
  frt_disp_e disp_sel;
  frt_cond_e disp_cond;
  logic [47:0] obs [6];
  logic [47:0] exp_q [$];
  int sel_q [$];
  int errors = 0, compares = 0, cycles = 0, s, i, j, n;
  longint f, inc, sp;
  longint secs [4] = '{1, 60, 3600, 86400};
  logic [6:0] kt [3] = '{7'h02, 7'h63, 7'h2d};
  int kseq [8] = '{0, 1, 0, 0, 1, 0, 0, 1};
  logic [3:0] dseq [8] = '{4'h8, 4'h9, 4'h1, 4'h9, 4'ha, 4'h2, 4'ha, 4'ha};
  logic [3:0] fseq [8] = '{4'h9, 4'h9, 4'h4, 4'h5, 4'h5, 4'h2, 4'h2, 4'h2};
  event chk;
  always #2.5 clk = ~clk;
  assign obs[0] = {16'h0, rate_out};
  assign obs[1] = {32'h0, ao_code};
  assign obs[2] = total_out;
  assign obs[3] = {44'h0, valve_auto, valve_open, valve_closed, disp_flash};
  assign obs[4] = {44'h0, disp_sel, disp_cond};
  assign obs[5] = {44'h0, relay_hi_alarm, relay_lo_alarm, print_enable, beep};
  frt_keypad_model i_frt_keypad_model (.clk(clk), .keys(keys));
  frt_flow_totalizer #(.SAMPLE_CYCLES(S), .VIEW_CYCLES(V), .ALT_CYCLES(16),
    .BLINK_CYCLES(8)) i_frt_flow_totalizer (.clk(clk), .nrst(nrst),
    .ovr_key(keys[0]), .inc_key(keys[1]), .rate_key(keys[2]),
    .total_key(keys[3]), .remote_open(remote_open),
    .remote_close(remote_close), .flow_controller_alarm_input(alarm),
    .cts_in(cts_in), .remote_sel(remote_sel), .norm_in(norm_in),
    .cal_load(cal_load), .span_in(span_in), .cutoff_in(cutoff_in),
    .filt_in(filt_in), .total_division_factor(fact), .timebase_in(tb_in),
    .alarm_relay_sel(rly), .total_clear(total_clear), .rate_out(rate_out),
    .ao_code(ao_code), .total_out(total_out), .valve_auto(valve_auto),
    .valve_open(valve_open), .valve_closed(valve_closed),
    .ovr_led(ovr_led), .disp_sel(disp_sel), .disp_cond(disp_cond),
    .disp_flash(disp_flash), .beep(beep), .relay_hi_alarm(relay_hi_alarm),
    .relay_lo_alarm(relay_lo_alarm), .print_enable(print_enable));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic note(input int k, input logic [47:0] v);
    sel_q.push_back(k);
    exp_q.push_back(v);
    -> chk;
  endtask
  task automatic cal(input longint a, input logic [15:0] c,
      input logic [6:0] k, input longint d, input logic [1:0] t);
    @(posedge clk);
    span_in <= a[31:0];
    cutoff_in <= c;
    filt_in <= k;
    fact <= d[31:0];
    tb_in <= t;
    cal_load <= 1'b1;
    @(posedge clk);
    cal_load <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever begin
    @(chk);
    while (exp_q.size() > 0) begin
      s = sel_q.pop_front();
      e = exp_q.pop_front();
      compares++;
      if (obs[s] !== e) begin
        errors++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, e, obs[s]);
      end
    end
  end
  // Whole run needs well under twenty thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    cyc(2);
    note(4, 48'h0);
    note(3, 48'h8);
    for (i = 0; i < 3; i++) begin
      rs = xs(rs);
      sp = 10000 + rs[31:16];
      cal(sp, 16'h0, 7'h01, 100, 2'h0);
      @(posedge clk);
      norm_in <= {1'b0, rs[14:0]};
      cyc(3 * S);
      f = longint'(norm_in) <<< 16;
      note(1, {32'h0, norm_in});
      note(0, 48'((sp * norm_in) >> 16));
      cal(sp, 16'h0, kt[i], 100, 2'h0);
      @(posedge clk);
      norm_in <= norm_in ^ 16'h8000;
      for (j = 0; j < 3; j++) begin
        old = ao_code;
        n = 0;
        while (ao_code === old && n < 4 * S) begin
          cyc(1);
          n++;
        end
        f = f + (((longint'(norm_in) <<< 16) - f) / longint'(kt[i]));
        note(1, 48'(f >>> 16));
      end
    end
    // Out of range loads must leave span and constant alone
    cal(10000, 16'h0, 7'h01, 100, 2'h0);
    cal(32'h3e7, 16'h0, 7'h64, 100, 2'h0);
    cal(32'h1dcd_6501, 16'h0, 7'h00, 0, 2'h0);
    @(posedge clk);
    norm_in <= 16'h4000;
    cyc(2 * S);
    note(1, 48'h4000);
    note(0, 48'h9c4);
    cal(10000, 16'h1f4, 7'h01, 100, 2'h0);
    @(posedge clk);
    total_clear <= 1'b1;
    @(posedge clk);
    total_clear <= 1'b0;
    cyc(3 * S);
    note(0, 48'h0);
    note(2, 48'h0);
    @(posedge clk);
    norm_in <= 16'h8000;
    cyc(2 * S);
    note(0, 48'h1388);
    for (i = 0; i < 4; i++) begin
      rs = xs(rs);
      f = 1 + rs % 200000;
      cal(10000, 16'h0, 7'h01, f, i[1:0]);
      cal(10000, 16'h0, 7'h01, 200001 + rs[7:0], i[1:0]);
      @(posedge clk);
      norm_in <= 16'hffff;
      total_clear <= 1'b1;
      cyc(2 * S);
      @(posedge clk);
      total_clear <= 1'b0;
      cyc(4 * S);
      inc = ((64'h270f * 64'h61a8) << 16) / (secs[i] * 1000 * f);
      note(2, 48'((4 * inc) >> 16));
      note(0, 48'h270f);
    end
    @(posedge clk);
    norm_in <= 16'h0000;
    for (i = 0; i < 8; i++) begin
      if (i == 6) begin
        @(posedge clk);
        remote_sel <= 1'b1;
      end
      i_frt_keypad_model.press(kseq[i]);
      cyc(1);
      note(4, {44'h0, dseq[i]});
      note(3, {44'h0, fseq[i]});
    end
    cyc(V);
    note(4, 48'h2);
    @(posedge clk);
    remote_open <= 1'b1;
    cyc(8);
    note(3, 48'h4);
    @(posedge clk);
    remote_open <= 1'b0;
    cyc(8);
    note(3, 48'h2);
    for (i = 1; i < 3; i++) begin
      rs = xs(rs);
      @(posedge clk);
      rly <= i[1:0];
      alarm <= 1'b1;
      cts_in <= rs[0];
      n = 0;
      while (disp_sel !== DISP_FAULT && n < 128) begin
        cyc(1);
        n++;
      end
      note(5, {44'h0, i == 1, i == 2, cts_in, 1'b1});
      @(posedge clk);
      alarm <= 1'b0;
      cyc(48);
      note(5, {44'h0, 2'h0, cts_in, 1'b0});
    end
    i_frt_keypad_model.press(3);
    cyc(1);
    note(4, 48'h6);
    i_frt_keypad_model.press(2);
    cyc(1);
    note(4, 48'h2);
    // Panel back to auto, so a remote close is visible against it
    @(posedge clk);
    remote_sel <= 1'b0;
    for (i = 0; i < 3; i++) begin
      i_frt_keypad_model.press(i == 1);
    end
    @(posedge clk);
    remote_sel <= 1'b1;
    remote_close <= 1'b1;
    cyc(8);
    note(3, 48'h2);
    @(posedge clk);
    remote_close <= 1'b0;
    cyc(8);
    note(3, 48'h8);
    cyc(2);
    report_and_stop();
  end
endmodule // tb_frt_flow_totalizer
`default_nettype wire
